/* design/sleep_wake_consts.svh */
// Offsets, field positions, reset values and timing counts of the sleep and wake control
`ifndef SLEEP_WAKE_CONSTS_SVH
`define SLEEP_WAKE_CONSTS_SVH
// Register word offsets (byte address = index * 4)
`define OFS_MAIN_CTRL 4'h0
`define OFS_CORE_CTRL 4'h1
`define OFS_STATUS 4'h2
`define OFS_EVENTS 4'h3
`define OFS_DELAYS 4'h4
// Main converter control fields
`define MAIN_PERMIT_BIT 0
`define MAIN_VSEL_BIT 1
// Core converter control fields
`define CORE_VOLT_LSB 0
`define CORE_SLP_LSB 4
`define CORE_OFF_BIT 8
`define CORE_VOLT_RST 4'h5
`define CORE_SLP_RST 4'h2
// Timing, 40 MHz clock
`define CLK_HZ 40_000_000
`define DEBOUNCE_MS 56
`define POR_HOLD_MS 20
`define RESET_PULSE_MS 2
`define SHUTDOWN_DELAY_MS 10
`endif

/* design/sleep_wake_pkg.sv */
// Types shared by the sleep and wake control
package sleep_wake_pkg;
   typedef enum logic [1:0] {st_off, st_on, st_low_power} power_state_t;
endpackage : sleep_wake_pkg

/* design/sleep_wake_reset_control.sv */
// Sleep entry and exit, debounced buttons, cover warning and reset outputs
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`include "sleep_wake_consts.svh"

// What this block does
// - Strap picks main default 3.0 or 3.3 V
// - Low power lowers core to sleep preset
// - Core-off bit disables core in low power
// - Sleep pin ignored while permit bit clear
// - Enter low power on rising AND edge
// - Leave on pin low, permit clear, buttons
// - Wake exit restores pre-sleep core voltage
// - Debounce wake button, event per press
// - Warm reset pulse only with core regulated
// - Warm reset keeps settings, exits low power
// - Cover low means removed, event on fall
// - Cover low drives power-fail warning low
// - Cover removal stops converters, LDOs reduced
// - Power-on reset follows first LDO good
// - Power-on reset held fixed time after settle
// - Reset pulse exits low power, fixed width
// - Processor reset low while power-on reset low
// - Warning low on UV, overtemp or cover
// - Warning low while power-on reset low
// - Debounce filters settle in 56 ms
// - Supplies off after warning delay
// - Power-on reset low holds processor reset, warning and events low
module sleep_wake_reset_control #(
   parameter int DEBOUNCE_CYCLES = (`CLK_HZ / 1000) * `DEBOUNCE_MS,
   parameter int POR_HOLD_CYCLES = (`CLK_HZ / 1000) * `POR_HOLD_MS,
   parameter int RESET_PULSE_CYCLES = (`CLK_HZ / 1000) * `RESET_PULSE_MS,
   parameter int SHUTDOWN_CYCLES = (`CLK_HZ / 1000) * `SHUTDOWN_DELAY_MS
) (
   input wire logic clk, // 40 MHz clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic [5:0] avs_address, // Word address
   input wire logic avs_read, // Read strobe
   input wire logic avs_write, // Write strobe
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall
   input wire logic main_default_strap, // Main rail default select
   input wire logic sleep_request_pin, // Deep sleep request
   input wire logic wake_button, // Wake push-button, active high
   input wire logic warm_reset_button_n, // Warm reset button, active low
   input wire logic cover_in, // Battery cover, high when fitted
   input wire logic first_linear_good, // First LDO power good
   input wire logic core_rail_good, // Core rail in regulation
   input wire logic undervoltage, // Supply below threshold
   input wire logic overtemp, // Overtemperature imminent
   output logic main_rail_3v3, // Main rail at 3.3 V
   output logic main_enable, // Main converter on
   output logic core_enable, // Core converter on
   output logic [3:0] core_rail_vsel, // Core rail voltage code
   output logic ldo_reduced, // LDOs in reduced-power mode
   output logic supplies_enable, // All supplies on
   output logic low_power_active, // Low power mode state
   output logic power_on_reset_out_n, // Power-on reset, active low
   output logic processor_reset_n, // Processor reset, active low
   output logic power_fail_warning_n, // Power-fail warning, active low
   output logic wake_event, // Wake press pulse for interrupt logic
   output logic cover_event // Cover removed pulse for interrupt logic
);

   localparam int DB_W = 32;

   // ****************************************
   // Debounce filters
   // ****************************************
   logic [2:0] raw_in;
   logic [2:0] stable;
   logic [2:0] stable_d;
   assign raw_in = {cover_in, ~warm_reset_button_n, wake_button};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_db
         logic [DB_W-1:0] cnt;
         // Input must hold its new level for the whole window before it is taken
         always_ff @(posedge clk) begin
            if (!rstn) begin
               cnt <= '0;
               stable[gi] <= (gi == 2) ? 1'b1 : 1'b0;
            end else if (raw_in[gi] == stable[gi]) begin
               cnt <= '0;
            end else if (cnt >= DB_W'(DEBOUNCE_CYCLES - 1)) begin
               cnt <= '0;
               stable[gi] <= raw_in[gi];
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   endgenerate

   // Edge memory of the filtered inputs
   always_ff @(posedge clk) begin
      if (!rstn) stable_d <= 3'b100;
      else stable_d <= stable;
   end

   logic wake_rise;
   logic warm_rise;
   logic cover_fall;
   assign wake_rise = stable[0] & ~stable_d[0];
   assign warm_rise = stable[1] & ~stable_d[1];
   assign cover_fall = ~stable[2] & stable_d[2];

   // ****************************************
   // Register file
   // ****************************************
   logic sleep_permit_bit;
   logic sleep_core_off_bit;
   logic [3:0] core_run_volt;
   logic [3:0] core_sleep_volt;
   logic strap_taken;
   logic [3:0] wake_count;
   logic [3:0] cover_count;
   logic hit_main;
   logic hit_core;
   assign hit_main = avs_write & ~avs_waitrequest & avs_byteenable[0] & (avs_address[3:0] == `OFS_MAIN_CTRL);
   assign hit_core = avs_write & ~avs_waitrequest & (avs_address[3:0] == `OFS_CORE_CTRL);

   // One wait cycle per access gives a registered answer
   always_ff @(posedge clk) begin
      if (!rstn) avs_waitrequest <= 1'b1;
      else if ((avs_read | avs_write) & avs_waitrequest) avs_waitrequest <= 1'b0;
      else avs_waitrequest <= 1'b1;
   end

   // Strap caught once after reset release, then software may change it
   always_ff @(posedge clk) begin
      if (!rstn) begin
         strap_taken <= 1'b0;
         main_rail_3v3 <= 1'b0;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         main_rail_3v3 <= main_default_strap;
      end else if (hit_main) begin
         main_rail_3v3 <= avs_writedata[`MAIN_VSEL_BIT];
      end
   end

   // Sleep permit; warm reset leaves it alone
   always_ff @(posedge clk) begin
      if (!rstn) sleep_permit_bit <= 1'b0;
      else if (hit_main) sleep_permit_bit <= avs_writedata[`MAIN_PERMIT_BIT];
   end

   // Core converter settings
   always_ff @(posedge clk) begin
      if (!rstn) begin
         core_run_volt <= `CORE_VOLT_RST;
         core_sleep_volt <= `CORE_SLP_RST;
         sleep_core_off_bit <= 1'b0;
      end else if (hit_core) begin
         if (avs_byteenable[0]) begin
            core_run_volt <= avs_writedata[`CORE_VOLT_LSB +: 4];
            core_sleep_volt <= avs_writedata[`CORE_SLP_LSB +: 4];
         end
         if (avs_byteenable[1]) sleep_core_off_bit <= avs_writedata[`CORE_OFF_BIT];
      end
   end

   // Wake press and cover removal counters make events visible to software; wrap is harmless
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wake_count <= '0;
         cover_count <= '0;
      end else begin
         if (wake_rise) wake_count <= wake_count + 1'b1;
         if (cover_fall) cover_count <= cover_count + 1'b1;
      end
   end

   // ****************************************
   // Low power state machine
   // ****************************************
   sleep_wake_pkg::power_state_t state;
   logic sleep_and;
   logic sleep_and_d;
   logic [3:0] saved_volt;
   logic fail_cond;
   logic reset_pulse_go;
   logic restore_hold;
   logic lp_exit;
   assign sleep_and = sleep_request_pin & sleep_permit_bit;
   assign fail_cond = undervoltage | overtemp | ~stable[2];
   assign lp_exit = (state == sleep_wake_pkg::st_low_power) &
                    (~sleep_and | wake_rise | warm_rise | reset_pulse_go);

   always_ff @(posedge clk) begin
      if (!rstn) sleep_and_d <= 1'b0;
      else sleep_and_d <= sleep_and;
   end

   // Entry only on an edge, so a held pin after wake does not re-enter
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= sleep_wake_pkg::st_off;
         saved_volt <= `CORE_VOLT_RST;
      end else begin
         case (state)
            sleep_wake_pkg::st_off: begin
               if (supplies_enable & stable[2]) state <= sleep_wake_pkg::st_on;
            end
            sleep_wake_pkg::st_on: begin
               if (!supplies_enable | ~stable[2]) state <= sleep_wake_pkg::st_off;
               else if (sleep_and & ~sleep_and_d & power_on_reset_out_n) begin
                  state <= sleep_wake_pkg::st_low_power;
                  saved_volt <= core_run_volt;
               end
            end
            sleep_wake_pkg::st_low_power: begin
               if (!supplies_enable | ~stable[2]) state <= sleep_wake_pkg::st_off;
               else if (lp_exit)
                  state <= sleep_wake_pkg::st_on;
            end
            default: state <= sleep_wake_pkg::st_off;
         endcase
      end
   end

   // Saved voltage rules after any exit to the on state until software writes the core word; set wins
   always_ff @(posedge clk) begin
      if (!rstn) restore_hold <= 1'b0;
      else if (lp_exit) restore_hold <= 1'b1;
      else if (hit_core) restore_hold <= 1'b0;
   end

   // Rail controls; core restored from the saved setting on any exit to the on state
   always_ff @(posedge clk) begin
      if (!rstn) begin
         main_enable <= 1'b0;
         core_enable <= 1'b0;
         core_rail_vsel <= `CORE_VOLT_RST;
         ldo_reduced <= 1'b0;
         low_power_active <= 1'b0;
      end else begin
         low_power_active <= (state == sleep_wake_pkg::st_low_power);
         main_enable <= supplies_enable & stable[2];
         ldo_reduced <= ~stable[2] | (state == sleep_wake_pkg::st_low_power);
         if (state == sleep_wake_pkg::st_low_power) begin
            core_enable <= ~sleep_core_off_bit & supplies_enable & stable[2];
            core_rail_vsel <= core_sleep_volt;
         end else begin
            core_enable <= supplies_enable & stable[2];
            core_rail_vsel <= (state == sleep_wake_pkg::st_on) ? saved_restore(restore_hold, saved_volt, core_run_volt)
                                                              : core_run_volt;
         end
      end
   end

   // Wake path returns the voltage held before sleep until software writes again
   function automatic logic [3:0] saved_restore(input logic hold, input logic [3:0] saved, input logic [3:0] run);
      saved_restore = hold ? saved : run;
   endfunction : saved_restore

   // ****************************************
   // Power-fail warning and supply shutdown
   // ****************************************
   logic [31:0] fail_cnt;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         fail_cnt <= '0;
         supplies_enable <= 1'b1;
      end else if (!fail_cond) begin
         fail_cnt <= '0;
         supplies_enable <= 1'b1;
      end else if (fail_cnt >= 32'(SHUTDOWN_CYCLES - 1)) begin
         supplies_enable <= 1'b0;
      end else begin
         fail_cnt <= fail_cnt + 1'b1;
      end
   end

   // Warning goes low at once; it is also held while power-on reset is low
   always_ff @(posedge clk) begin
      if (!rstn) power_fail_warning_n <= 1'b0;
      else power_fail_warning_n <= ~fail_cond & power_on_reset_out_n & first_linear_good;
   end

   // ****************************************
   // Power-on reset and processor reset
   // ****************************************
   logic [31:0] por_cnt;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         por_cnt <= '0;
         power_on_reset_out_n <= 1'b0;
      end else if (!first_linear_good) begin
         por_cnt <= '0;
         power_on_reset_out_n <= 1'b0;
      end else if (por_cnt >= 32'(POR_HOLD_CYCLES - 1)) begin
         power_on_reset_out_n <= 1'b1;
      end else begin
         por_cnt <= por_cnt + 1'b1;
      end
   end

   // Warm press is remembered until the core rail is regulated
   logic warm_pending;
   logic [31:0] rst_cnt;
   assign reset_pulse_go = warm_pending & core_rail_good & power_on_reset_out_n;
   always_ff @(posedge clk) begin
      if (!rstn) warm_pending <= 1'b0;
      else if (warm_rise) warm_pending <= 1'b1; // Set wins over the clear
      else if (reset_pulse_go) warm_pending <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rst_cnt <= '0;
         processor_reset_n <= 1'b0;
      end else if (!power_on_reset_out_n | !first_linear_good) begin
         rst_cnt <= '0;
         processor_reset_n <= 1'b0;
      end else if (reset_pulse_go) begin
         rst_cnt <= 32'(RESET_PULSE_CYCLES);
         processor_reset_n <= 1'b0;
      end else if (rst_cnt > 32'd1) begin
         rst_cnt <= rst_cnt - 1'b1;
      end else begin
         rst_cnt <= '0;
         processor_reset_n <= 1'b1;
      end
   end

   // ****************************************
   // Event pulses and read data
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wake_event <= 1'b0;
         cover_event <= 1'b0;
      end else begin
         wake_event <= wake_rise & power_on_reset_out_n & first_linear_good;
         cover_event <= cover_fall & power_on_reset_out_n & first_linear_good;
      end
   end

   // Unmapped words of the low 16 read zero; address bits 5:4 are not decoded
   always_ff @(posedge clk) begin
      if (!rstn) avs_readdata <= '0;
      else if (avs_read & avs_waitrequest) begin
         case (avs_address[3:0])
            `OFS_MAIN_CTRL: avs_readdata <= {30'd0, main_rail_3v3, sleep_permit_bit};
            `OFS_CORE_CTRL: avs_readdata <= {23'd0, sleep_core_off_bit, core_sleep_volt, core_run_volt};
            `OFS_STATUS: avs_readdata <= {24'd0, core_rail_vsel, stable, low_power_active};
            `OFS_EVENTS: avs_readdata <= {24'd0, cover_count, wake_count};
            default: avs_readdata <= '0;
         endcase
      end
   end

endmodule : sleep_wake_reset_control

/* tb/sleep_wake_chk.sv */
// Port checker of the sleep and wake control, bound to its top module
module sleep_wake_chk #(
   parameter int POR_HOLD_CYCLES = 12,
   parameter int RESET_PULSE_CYCLES = 6
) (
   input wire logic clk, // Clock
   input wire logic rstn, // Reset, active low
   input wire logic avs_read, // Read strobe
   input wire logic avs_write, // Write strobe
   input wire logic avs_waitrequest, // Stall
   input wire logic first_linear_good, // LDO good
   input wire logic undervoltage, // Low supply
   input wire logic overtemp, // Too hot
   input wire logic sleep_request_pin, // Sleep pin
   input wire logic supplies_enable, // Supplies on
   input wire logic low_power_active, // Sleep state
   input wire logic power_on_reset_out_n, // Power-on reset
   input wire logic processor_reset_n, // Processor reset
   input wire logic power_fail_warning_n, // Warning
   input wire logic wake_event, // Wake pulse
   input wire logic cover_event // Cover pulse
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [15:0] good_cnt;
   logic [15:0] pulse_cnt;
   logic por_d;
   // Pulses forced by power-on reset, release cycle included, are not counted
   always_ff @(posedge clk) begin
      por_d <= power_on_reset_out_n;
      good_cnt <= (!rstn || !first_linear_good || power_on_reset_out_n) ? 16'h0000 : good_cnt + 16'h0001;
      pulse_cnt <= (!rstn || processor_reset_n || !power_on_reset_out_n || !por_d) ? 16'h0000
                                                                                  : pulse_cnt + 16'h0001;
   end
   a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not after one wait cycle");
   a_por_follows_ldo: assert property (!first_linear_good |=> !power_on_reset_out_n)
      else $error("power-on reset high without LDO good");
   a_por_hold_time: assert property ($rose(power_on_reset_out_n) |->
      good_cnt >= POR_HOLD_CYCLES && good_cnt <= POR_HOLD_CYCLES + 1)
      else $error("power-on reset hold time wrong");
   a_por_holds_all: assert property (!power_on_reset_out_n |-> !processor_reset_n && !power_fail_warning_n)
      else $error("outputs released during power-on reset");
   a_fault_warns: assert property (undervoltage || overtemp |=> !power_fail_warning_n)
      else $error("no warning on supply fault");
   a_sleep_needs_pin: assert property ($rose(low_power_active) |-> $past(sleep_request_pin))
      else $error("low power entered without request");
   a_reset_width: assert property ($rose(processor_reset_n) && pulse_cnt != 16'h0000 |->
      pulse_cnt == 16'(RESET_PULSE_CYCLES))
      else $error("processor reset pulse width wrong");
   a_reset_wakes: assert property (!processor_reset_n && power_on_reset_out_n |-> ##[1:3] !low_power_active)
      else $error("reset pulse left low power on");
   a_wake_pulse: assert property (wake_event |=> !wake_event)
      else $error("wake event longer than a cycle");
   a_cover_warns: assert property (cover_event |-> ##[0:2] !power_fail_warning_n)
      else $error("no warning on cover removal");
   a_shutdown_late: assert property ($fell(supplies_enable) |-> $past(power_fail_warning_n, 8) == 1'b0)
      else $error("supplies cut without warning delay");
   c_sleep: cover property ($rose(low_power_active));
   c_wake: cover property (wake_event);
   c_cover: cover property (cover_event);
   c_pulse: cover property ($rose(processor_reset_n) && pulse_cnt != 16'h0000);
endmodule : sleep_wake_chk

bind sleep_wake_reset_control sleep_wake_chk #(.POR_HOLD_CYCLES(POR_HOLD_CYCLES),
   .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) sleep_wake_chk_i (.clk, .rstn, .avs_read, .avs_write,
   .avs_waitrequest, .first_linear_good, .undervoltage, .overtemp, .sleep_request_pin, .supplies_enable,
   .low_power_active, .power_on_reset_out_n, .processor_reset_n, .power_fail_warning_n, .wake_event, .cover_event);

/* tb/processor_model.sv */
// Application processor sleep pin and user push-buttons
module processor_model (
   input wire logic clk, // Clock
   input wire logic want_sleep, // Sleep wish of the software
   input wire logic press_wake, // Finger on wake button
   input wire logic press_warm, // Finger on warm reset button
   output logic sleep_request_pin = 1'b0, // Sleep request
   output logic wake_button = 1'b0, // Pulled down when free
   output logic warm_reset_button_n = 1'b1 // Pulled up when free
);
   // Re-entry only by a fresh pin edge, the port never pulses by itself
   always_ff @(posedge clk) begin
      sleep_request_pin <= want_sleep;
      wake_button <= press_wake;
      warm_reset_button_n <= !press_warm;
   end
endmodule : processor_model

/* tb/tb_top.sv */
// Self-checking bench of the sleep and wake control
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DB = 8;
   logic clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rdata;
   logic [3:0] avs_byteenable = 4'hf, core_rail_vsel;
   logic main_default_strap = 1'b1, cover_in = 1'b1, first_linear_good = 1'b0, core_rail_good = 1'b1;
   logic undervoltage = 1'b0, overtemp = 1'b0, want_sleep = 1'b0, press_wake = 1'b0, press_warm = 1'b0;
   logic sleep_request_pin, wake_button, warm_reset_button_n, avs_waitrequest, main_rail_3v3, main_enable;
   logic core_enable, ldo_reduced, supplies_enable, low_power_active, power_on_reset_out_n;
   logic processor_reset_n, power_fail_warning_n, wake_event, cover_event;
   int mismatches = 0, comparisons = 0;
   sleep_wake_reset_control #(.DEBOUNCE_CYCLES(DB), .POR_HOLD_CYCLES(12), .RESET_PULSE_CYCLES(6),
      .SHUTDOWN_CYCLES(10)) sleep_wake_reset_control_i (.clk, .rstn, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .main_default_strap, .sleep_request_pin,
      .wake_button, .warm_reset_button_n, .cover_in, .first_linear_good, .core_rail_good, .undervoltage,
      .overtemp, .main_rail_3v3, .main_enable, .core_enable, .core_rail_vsel, .ldo_reduced, .supplies_enable,
      .low_power_active, .power_on_reset_out_n, .processor_reset_n, .power_fail_warning_n, .wake_event,
      .cover_event);
   processor_model processor_model_i (.clk, .want_sleep, .press_wake, .press_warm, .sleep_request_pin,
      .wake_button, .warm_reset_button_n);
   // 40 MHz clock
   always #12.5 clk = ~clk;
   // ***************************************
   // Bus cycles, waits and comparisons
   // ***************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Starts one edge late so a release and a new request never share a step
   // Waits as long as the slave stalls; only the watchdog ends a hang
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic rd_check(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(rdata, exp);
   endtask : rd_check
   // Bounded wait for a level, a hang counts as a mismatch
   task automatic wait_for(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 400) begin
         @(posedge clk);
         n++;
      end
      check(s, v);
   endtask : wait_for
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   // Watchdog, the tests need under 2000 cycles
   initial begin
      cyc(20000);
      mismatches++;
      complete_run();
   end
   // ***************************************
   // Tests
   // ***************************************
   initial begin
      cyc(8);
      check({processor_reset_n, power_fail_warning_n, power_on_reset_out_n}, 0);
      rstn <= 1'b1;
      cyc(2);
      check(main_rail_3v3, 1);
      rd_check(6'h01, 32'h0000_0025);
      rd_check(6'h04, 32'h0000_0000);
      rd_check(6'h3f, 32'h0000_0000);
      check(power_on_reset_out_n, 0);
      first_linear_good <= 1'b1;
      wait_for(power_on_reset_out_n, 1'b1);
      wait_for(processor_reset_n, 1'b1);
      check(power_fail_warning_n, 1);
      $display("test power-on done");
      bus(1'b1, 6'h00, 32'h0000_0002);
      want_sleep <= 1'b1;
      cyc(DB);
      check({low_power_active, core_enable}, 1);
      bus(1'b1, 6'h00, 32'h0000_0003);
      cyc(4);
      check({low_power_active, core_rail_vsel}, 5'h12);
      want_sleep <= 1'b0;
      cyc(5);
      check({low_power_active, core_rail_vsel}, 5'h05);
      $display("test sleep pin done");
      want_sleep <= 1'b1;
      cyc(5);
      check(low_power_active, 1);
      bus(1'b1, 6'h01, 32'h0000_0027);
      press_wake <= 1'b1;
      wait_for(wake_event, 1'b1);
      press_wake <= 1'b0;
      cyc(4);
      check({low_power_active, core_rail_vsel}, 5'h05);
      cyc(DB + 4);
      check(low_power_active, 0);
      rd_check(6'h03, 32'h0000_0001);
      $display("test wake done");
      bus(1'b1, 6'h01, 32'h0000_0125);
      want_sleep <= 1'b0;
      cyc(2);
      want_sleep <= 1'b1;
      cyc(5);
      check({low_power_active, core_enable}, 2);
      core_rail_good <= 1'b0;
      press_warm <= 1'b1;
      cyc(DB + 6);
      check({low_power_active, processor_reset_n}, 1);
      press_warm <= 1'b0;
      core_rail_good <= 1'b1;
      wait_for(processor_reset_n, 1'b0);
      wait_for(processor_reset_n, 1'b1);
      rd_check(6'h01, 32'h0000_0125);
      rd_check(6'h00, 32'h0000_0003);
      $display("test warm reset done");
      for (int i = 0; i < 2; i++) begin
         {undervoltage, overtemp} <= (i == 0) ? 2'b10 : 2'b01;
         cyc(2);
         check(power_fail_warning_n, 0);
         {undervoltage, overtemp} <= 2'b00;
         cyc(2);
         check(power_fail_warning_n, 1);
      end
      $display("test faults done");
      cover_in <= 1'b0;
      wait_for(cover_event, 1'b1);
      cyc(2);
      check(power_fail_warning_n, 0);
      check({main_enable, core_enable, ldo_reduced}, 1);
      wait_for(supplies_enable, 1'b0);
      rd_check(6'h03, 32'h0000_0011);
      $display("test cover done");
      complete_run();
   end
endmodule : tb_top
